// ### logic/swr_defines.svh
// Purpose: Constants for the single-wire slave ROM layer and slot timing.
// Assumes: 250 MHz clock; times are given in nanoseconds.
// Notes:   Cycle counts are derived from the times by the macros below.
//
// Behaviour
// - Skip command CCh selects the device with no identification sequence.
// - The line is only ever pulled low, never driven high.
// - Search F0h: per id bit send bit, complement, then take master's bit.
// - Conditional search ECh: join only when the condition holds, else idle.
// - Condition: any enabled control bit at 20Eh whose status flag is 1.
// - A completed conditional search leaves the device selected.
// - Overdrive skip 3Ch selects the device and sets fast speed.
// - Overdrive match 69h: id at fast speed; only an exact match selects.
// - A device already fast stays fast when a fast match misses it.
// - A reset low time of 480 us or more returns to standard speed.
// - A fast device stays fast after a reset of at most 80 us.
// - Reset is seen after 480 us low at standard or 62 us at fast speed.
// - After reset release, wait presence delay then pull low presence time.
// - Slots are accepted right after the presence pulse ends.
// - Master starts all signals; the device times all at current speed.
// - Each slot starts on a master falling edge, starting the slot timer.
// - A write slot is decoded from the line level at the sampling point.
// - Order: reset and presence, addressing byte, function command, data.
// - Match 55h: 64 id bits; only an exact match proceeds.
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

`define SWR_CLK_MHZ        250
`define SWR_CYC_UP(ns)     ((((ns) * `SWR_CLK_MHZ) + 999) / 1000)
`define SWR_CYC_DN(ns)     (((ns) * `SWR_CLK_MHZ) / 1000)

`define SWR_CTRL_ADDR      16'h020e
`define SWR_CTRL_RESET     8'h00
`define SWR_CTRL_ALARM_BIT 0
`define SWR_CTRL_HIGH_BIT  1
`define SWR_CTRL_LOW_BIT   2

`define SWR_CMD_SKIP       8'hcc
`define SWR_CMD_SEARCH     8'hf0
`define SWR_CMD_COND       8'hec
`define SWR_CMD_MATCH      8'h55
`define SWR_CMD_FSKIP      8'h3c
`define SWR_CMD_FMATCH     8'h69

`define SWR_RSTL_STD_NS    480000
`define SWR_RSTL_FAST_NS   62000
`define SWR_RSTL_KEEP_NS   80000
`define SWR_PDH_STD_NS     30000
`define SWR_PDH_FAST_NS    3000
`define SWR_PDL_STD_NS     120000
`define SWR_PDL_FAST_NS    12000
`define SWR_SMP_STD_NS     30000
`define SWR_SMP_FAST_NS    3000
`define SWR_HOLD_STD_NS    45000
`define SWR_HOLD_FAST_NS   4500

`endif

// ### logic/swr_pkg.sv
// Purpose: Types shared by the single-wire slave logic.
// Assumes: Nothing beyond the defines header.
// Notes:   State is one-hot.
`default_nettype none
package swr_pkg;

  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_PRES_WAIT = 8'h02,
    ST_PRES_LOW  = 8'h04,
    ST_CMD       = 8'h08,
    ST_SEARCH    = 8'h10,
    ST_MATCH     = 8'h20,
    ST_FUNC      = 8'h40,
    ST_WAIT      = 8'h80
  } swr_state_t;

  typedef struct packed {
    swr_state_t  st;
    logic        od;
    logic        od_prev;
    logic        m69;
    logic [1:0]  ph;
    logic [5:0]  idx;
    logic [7:0]  sh;
    logic [17:0] low_cnt;
    logic [17:0] cnt;
    logic        rst_seen;
    logic        dq_prev;
    logic        pull_n;
    logic        dq_out;
    logic        sel;
    logic [7:0]  ctrl;
    logic [7:0]  rdata;
    logic        rx_bit;
    logic        rx_valid;
  } swr_regs_t;

  typedef struct packed {
    logic        run;
    logic [17:0] cnt;
    logic        smp;
    logic        hold;
  } swr_tmr_t;

endpackage : swr_pkg
`default_nettype wire

// ### logic/swr_slot_timer.sv
// Purpose: Slot time base started on each master falling edge.
// Assumes: start is a one-cycle pulse; fast selects overdrive timing.
// Notes:   Ticks come one cycle after the count reaches its limit.
`timescale 1ns/1ns
`default_nettype none
module swr_slot_timer
  import swr_pkg::*;
#(
  parameter int unsigned SMP_STD  = 7500,
  parameter int unsigned SMP_FAST = 750,
  parameter int unsigned HOLD_STD = 11250,
  parameter int unsigned HOLD_FAST = 1125
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Control
  input  wire logic start,
  input  wire logic fast,
  // Ticks
  output var  logic sample_tick,
  output var  logic hold_tick
);

  swr_tmr_t    t_q;
  swr_tmr_t    t_d;
  logic [17:0] smp_lim;
  logic [17:0] hold_lim;

  always_comb begin
    t_d      = t_q;
    t_d.smp  = 1'b0;
    t_d.hold = 1'b0;
    smp_lim  = fast ? 18'(SMP_FAST) : 18'(SMP_STD);
    hold_lim = fast ? 18'(HOLD_FAST) : 18'(HOLD_STD);
    if (start) begin
      t_d.run = 1'b1;
      t_d.cnt = 18'h00001;
    end else if (t_q.run) begin
      t_d.cnt = t_q.cnt + 18'h00001;
      t_d.smp = (t_q.cnt == smp_lim);
      t_d.hold = (t_q.cnt == hold_lim);
      if (t_q.cnt >= smp_lim && t_q.cnt >= hold_lim) begin
        t_d.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign sample_tick = t_q.smp;
  assign hold_tick   = t_q.hold;

endmodule : swr_slot_timer
`default_nettype wire

// ### logic/swr_top.sv
// Purpose: Slave ROM layer, reset/presence and slot sampling of the link.
// Assumes: dq_in is synchronous to clk; the wire is pulled up outside.
// Notes:   Memory functions sit beyond the func_* ports.
`timescale 1ns/1ns
`default_nettype none
`include "swr_defines.svh"
module swr_top
  import swr_pkg::*;
#(
  parameter logic [63:0] ROM_ID   = 64'h0123_4567_89ab_cd01, // arbitrary
  parameter int unsigned RST_STD  = `SWR_CYC_UP(`SWR_RSTL_STD_NS),
  parameter int unsigned RST_FAST = `SWR_CYC_UP(`SWR_RSTL_FAST_NS),
  parameter int unsigned RST_KEEP = `SWR_CYC_DN(`SWR_RSTL_KEEP_NS),
  parameter int unsigned PDH_STD  = `SWR_CYC_UP(`SWR_PDH_STD_NS),
  parameter int unsigned PDH_FAST = `SWR_CYC_UP(`SWR_PDH_FAST_NS),
  parameter int unsigned PDL_STD  = `SWR_CYC_UP(`SWR_PDL_STD_NS),
  parameter int unsigned PDL_FAST = `SWR_CYC_UP(`SWR_PDL_FAST_NS),
  parameter int unsigned SMP_STD  = `SWR_CYC_UP(`SWR_SMP_STD_NS),
  parameter int unsigned SMP_FAST = `SWR_CYC_UP(`SWR_SMP_FAST_NS),
  parameter int unsigned HOLD_STD = `SWR_CYC_UP(`SWR_HOLD_STD_NS),
  parameter int unsigned HOLD_FAST = `SWR_CYC_UP(`SWR_HOLD_FAST_NS)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Data line, open drain
  input  wire logic        dq_in,
  output var  logic        dq_out,
  output var  logic        dq_oe_n,
  // Status flags from the logging core
  input  wire logic        alarm_flag,
  input  wire logic        high_trip_flag,
  input  wire logic        low_trip_flag,
  // Register port from the memory function layer
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wr_data,
  output var  logic [7:0]  reg_rd_data,
  // Memory function bit stream
  input  wire logic        func_tx_en,
  input  wire logic        func_tx_bit,
  output var  logic        func_bit,
  output var  logic        func_bit_valid,
  // Link state
  output var  logic        selected,
  output var  logic        fast_speed_flag
);

  swr_regs_t   r;
  swr_regs_t   n;
  logic        fall;
  logic        rise;
  logic        slot_start;
  logic        sample_tick;
  logic        hold_tick;
  logic        cond;
  logic        id_bit;
  logic        tx_zero;
  logic        dec_ev;
  logic        search_bad;
  logic        search_done;
  logic        match_bad;
  logic        match_done;
  logic        rst_hit;
  logic [7:0]  byte_in;
  logic [17:0] rst_lim;
  logic [17:0] pdh_lim;
  logic [17:0] pdl_lim;

  localparam swr_regs_t RST_VAL = '{
    st: ST_IDLE, od: 1'b0, od_prev: 1'b0, m69: 1'b0, ph: 2'h0, idx: 6'h00,
    sh: 8'h00, low_cnt: 18'h00000, cnt: 18'h00000, rst_seen: 1'b0,
    dq_prev: 1'b1, pull_n: 1'b1, dq_out: 1'b0, sel: 1'b0,
    ctrl: `SWR_CTRL_RESET, rdata: 8'h00, rx_bit: 1'b0, rx_valid: 1'b0};

  swr_slot_timer #(
    .SMP_STD   (SMP_STD),
    .SMP_FAST  (SMP_FAST),
    .HOLD_STD  (HOLD_STD),
    .HOLD_FAST (HOLD_FAST)
  ) u_timer (
    .clk         (clk),
    .srst        (srst),
    .start       (slot_start),
    .fast        (r.od),
    .sample_tick (sample_tick),
    .hold_tick   (hold_tick)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    n           = r;
    n.rx_valid  = 1'b0;
    n.dq_prev   = dq_in;
    slot_start  = 1'b0;
    dec_ev      = 1'b0;
    search_bad  = 1'b0;
    search_done = 1'b0;
    match_bad   = 1'b0;
    match_done  = 1'b0;
    // Our own pull-down never counts as a master edge.
    fall    = r.dq_prev & ~dq_in & r.pull_n;
    rise    = ~r.dq_prev & dq_in;
    rst_lim = r.od ? 18'(RST_FAST) : 18'(RST_STD);
    pdh_lim = r.od ? 18'(PDH_FAST) : 18'(PDH_STD);
    pdl_lim = r.od ? 18'(PDL_FAST) : 18'(PDL_STD);
    cond    = |(r.ctrl[2:0] & {low_trip_flag, high_trip_flag,
                               alarm_flag});
    id_bit  = ROM_ID[r.idx];
    byte_in = {dq_in, r.sh[7:1]};
    tx_zero = 1'b0;
    case (r.st)
      ST_SEARCH: tx_zero = (r.ph == 2'h0) ? ~id_bit
                         : (r.ph == 2'h1) ? id_bit : 1'b0;
      ST_FUNC:   tx_zero = func_tx_en & ~func_tx_bit;
      default:   tx_zero = 1'b0;
    endcase

    if (reg_wr_en && reg_addr == `SWR_CTRL_ADDR) begin
      n.ctrl = reg_wr_data;
    end
    n.rdata = (reg_addr == `SWR_CTRL_ADDR) ? r.ctrl : 8'h00;

    // The count runs whoever pulls, so a reset that begins during our
    // own read-zero or search reply is still seen in full.
    if (dq_in) begin
      n.low_cnt = 18'h00000;
    end else if (r.low_cnt != 18'h3ffff) begin
      n.low_cnt = r.low_cnt + 18'h00001;
    end

    case (r.st)
      ST_IDLE, ST_WAIT: begin
        n.pull_n = 1'b1;
      end
      ST_PRES_WAIT: begin
        n.cnt = r.cnt + 18'h00001;
        if (r.cnt + 18'h00001 >= pdh_lim) begin
          n.st     = ST_PRES_LOW;
          n.cnt    = 18'h00000;
          n.pull_n = 1'b0;
        end
      end
      ST_PRES_LOW: begin
        n.cnt = r.cnt + 18'h00001;
        if (r.cnt + 18'h00001 >= pdl_lim) begin
          n.pull_n = 1'b1;
          n.st     = ST_CMD;
          n.idx    = 6'h00;
          n.ph     = 2'h0;
        end
      end
      ST_CMD, ST_SEARCH, ST_MATCH, ST_FUNC: begin
        if (fall) begin
          slot_start = 1'b1;
          n.pull_n   = ~tx_zero;
        end
        if (hold_tick) begin
          n.pull_n = 1'b1;
        end
        if (sample_tick) begin
          case (r.st)
            ST_CMD: begin
              n.sh  = byte_in;
              n.idx = r.idx + 6'h01;
              if (r.idx == 6'h07) begin
                dec_ev = 1'b1;
                n.idx  = 6'h00;
                n.ph   = 2'h0;
                case (byte_in)
                  `SWR_CMD_SKIP:   n.st = ST_FUNC;
                  `SWR_CMD_FSKIP: begin
                    n.st = ST_FUNC;
                    n.od = 1'b1;
                  end
                  `SWR_CMD_SEARCH: n.st = ST_SEARCH;
                  `SWR_CMD_COND:   n.st = cond ? ST_SEARCH : ST_WAIT;
                  `SWR_CMD_MATCH: begin
                    n.st      = ST_MATCH;
                    n.m69     = 1'b0;
                    n.od_prev = r.od;
                  end
                  `SWR_CMD_FMATCH: begin
                    n.st      = ST_MATCH;
                    n.m69     = 1'b1;
                    n.od_prev = r.od;
                    n.od      = 1'b1;
                  end
                  default:         n.st = ST_WAIT;
                endcase
              end
            end
            ST_SEARCH: begin
              if (r.ph != 2'h2) begin
                n.ph = r.ph + 2'h1;
              end else if (dq_in != id_bit) begin
                search_bad = 1'b1;
                n.st       = ST_WAIT;
              end else begin
                n.ph  = 2'h0;
                n.idx = r.idx + 6'h01;
                if (r.idx == 6'h3f) begin
                  search_done = 1'b1;
                  n.st        = ST_FUNC;
                end
              end
            end
            ST_MATCH: begin
              if (dq_in != id_bit) begin
                match_bad = 1'b1;
                n.st      = ST_WAIT;
                if (r.m69) begin
                  n.od = r.od_prev;
                end
              end else begin
                n.idx = r.idx + 6'h01;
                if (r.idx == 6'h3f) begin
                  match_done = 1'b1;
                  n.st       = ST_FUNC;
                end
              end
            end
            default: begin
              n.rx_bit   = dq_in;
              n.rx_valid = 1'b1;
            end
          endcase
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // A reset pulse overrides every state, including an unknown command.
    rst_hit = (r.low_cnt >= rst_lim) && r.pull_n;
    if (rst_hit) begin
      n.rst_seen = 1'b1;
      n.st       = ST_IDLE;
    end
    if (rise && r.rst_seen) begin
      n.rst_seen = 1'b0;
      n.st       = ST_PRES_WAIT;
      n.cnt      = 18'h00000;
      // Shorter resets at fast speed keep the device fast.
      if (r.low_cnt >= 18'(RST_STD)) begin
        n.od = 1'b0;
      end
    end
    n.sel = (n.st == ST_FUNC);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign dq_out          = r.dq_out;
  assign dq_oe_n         = r.pull_n;
  assign reg_rd_data     = r.rdata;
  assign func_bit        = r.rx_bit;
  assign func_bit_valid  = r.rx_valid;
  assign selected        = r.sel;
  assign fast_speed_flag = r.od;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_skip_select: assert property (@(posedge clk) disable iff (srst)
    dec_ev && byte_in == `SWR_CMD_SKIP && !rst_hit |=> r.sel && selected)
    else $error("skip command did not select");
  a_fast_skip: assert property (@(posedge clk) disable iff (srst)
    dec_ev && byte_in == `SWR_CMD_FSKIP && !rst_hit |=> r.od && r.sel)
    else $error("fast skip did not set fast speed");
  a_cond_quiet: assert property (@(posedge clk) disable iff (srst)
    dec_ev && byte_in == `SWR_CMD_COND && !cond && !rst_hit
    |=> r.st == ST_WAIT ##1 dq_oe_n)
    else $error("conditional search joined without condition");
  a_search_drop: assert property (@(posedge clk) disable iff (srst)
    search_bad && !rst_hit |=> r.st == ST_WAIT && !selected)
    else $error("search mismatch did not drop out");
  a_search_sel: assert property (@(posedge clk) disable iff (srst)
    search_done && !rst_hit |=> selected)
    else $error("resolved search did not select");
  a_fast_match: assert property (@(posedge clk) disable iff (srst)
    match_done && r.m69 && !rst_hit |=> fast_speed_flag && selected)
    else $error("fast match did not select at fast speed");
  a_fast_keep: assert property (@(posedge clk) disable iff (srst)
    match_bad && r.od_prev && !rst_hit |=> fast_speed_flag)
    else $error("missed fast match dropped fast speed");
  a_long_reset: assert property (@(posedge clk) disable iff (srst)
    rise && r.rst_seen && r.low_cnt >= 18'(RST_STD) |=> !fast_speed_flag)
    else $error("long reset kept fast speed");
  a_short_reset: assert property (@(posedge clk) disable iff (srst)
    rise && r.rst_seen && r.od && r.low_cnt <= 18'(RST_KEEP)
    |=> fast_speed_flag)
    else $error("short reset left fast speed");
  a_presence_low: assert property (@(posedge clk) disable iff (srst)
    $rose(r.st == ST_PRES_LOW) |-> !dq_oe_n && $past(r.st) == ST_PRES_WAIT)
    else $error("presence pulse not driven after delay");

endmodule : swr_top
`default_nettype wire

// ### tb/swr_master_model.sv
// Purpose: Bus master model that starts every slot on the wire.
// Assumes: Tasks are entered right after a rising clock edge.
// Notes:   Counts suit the shortened timing used by the bench.
`timescale 1ns/1ns
`default_nettype none
module swr_master_model (
  // Clock and speed
  input  wire logic clk,
  input  wire logic fast,
  // Wire
  input  wire logic line,
  output var  logic drive_low,
  // Bits seen by the master
  output var  logic rx_valid,
  output var  logic rx_bit
);
  initial begin
    drive_low = 1'b0;
    rx_valid  = 1'b0;
    rx_bit    = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic take();
    rx_bit   <= line;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : take

  task automatic reset_pulse(input int low);
    drive_low <= 1'b1;
    idle(low);
    drive_low <= 1'b0;
    idle(fast ? 9 : 18);
    take();
    // The window outlasts the slowest presence plus recovery.
    idle(fast ? 11 : 22);
  endtask : reset_pulse

  task automatic write_bit(input logic b);
    drive_low <= 1'b1;
    idle(b ? 1 : (fast ? 12 : 20));
    drive_low <= 1'b0;
    idle(b ? (fast ? 19 : 39) : (fast ? 8 : 20));
  endtask : write_bit

  task automatic read_bit();
    drive_low <= 1'b1;
    idle(1);
    drive_low <= 1'b0;
    idle(fast ? 4 : 5);
    take();
    idle(fast ? 14 : 33);
  endtask : read_bit
endmodule : swr_master_model
`default_nettype wire

// ### tb/test_swr_top.sv
// Purpose: Self-checking bench for the slave ROM layer and slots.
// Assumes: Shortened timing parameters; a single slave on the wire.
// Notes:   Master bits and function bits are compared from queues.
`timescale 1ns/1ns
`default_nettype none
`include "swr_defines.svh"
module test_swr_top;
  localparam logic [63:0] ID = 64'h5a3c_96e1_0f72_b4c8;
  localparam logic [15:0] CA = `SWR_CTRL_ADDR;
  logic        clk, srst, line, m_drive, m_fast, m_rx_valid, m_rx_bit;
  logic        dq_out, dq_oe_n, alarm_flag, high_trip_flag, low_trip_flag;
  logic        reg_wr_en, func_tx_en, func_tx_bit, func_bit, quiet;
  logic        func_bit_valid, selected, fast_speed_flag;
  logic [15:0] reg_addr, ra;
  logic [7:0]  reg_wr_data, reg_rd_data;
  logic [31:0] rv;
  logic        exp_q[$];
  logic        fb_q[$];
  int          fail_count, compares, cycles;

  // Open drain wire with a pull-up: any party pulling wins.
  assign line = ~m_drive & (dq_oe_n | dq_out);

  swr_top #(.ROM_ID(ID), .RST_STD(200), .RST_FAST(40), .RST_KEEP(60),
    .PDH_STD(8), .PDH_FAST(4), .PDL_STD(20), .PDL_FAST(10),
    .SMP_STD(10), .SMP_FAST(5), .HOLD_STD(15), .HOLD_FAST(7)) dut (
    .clk(clk), .srst(srst), .dq_in(line), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .alarm_flag(alarm_flag),
    .high_trip_flag(high_trip_flag), .low_trip_flag(low_trip_flag),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .func_tx_en(func_tx_en),
    .func_tx_bit(func_tx_bit), .func_bit(func_bit),
    .func_bit_valid(func_bit_valid), .selected(selected),
    .fast_speed_flag(fast_speed_flag));

  swr_master_model mm (
    .clk(clk), .fast(m_fast), .line(line), .drive_low(m_drive),
    .rx_valid(m_rx_valid), .rx_bit(m_rx_bit));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (m_rx_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk(8'h01, 8'h00);
      else
        chk(m_rx_bit, exp_q.pop_front());
    end
    if (func_bit_valid === 1'b1 && !quiet) begin
      if (fb_q.size() == 0)
        chk(8'h01, 8'h00);
      else
        chk(func_bit, fb_q.pop_front());
    end
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Stimulus tasks
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    chk(reg_rd_data, e);
  endtask : reg_rd

  task automatic wreset(input int low);
    quiet = 1'b1;
    exp_q.push_back(1'b0);
    mm.reset_pulse(low);
    quiet = 1'b0;
  endtask : wreset

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      mm.write_bit(b[i]);
  endtask : send_byte

  task automatic match(input logic [7:0] cmd, input logic [63:0] id);
    send_byte(cmd);
    if (cmd == `SWR_CMD_FMATCH)
      m_fast = 1'b1;
    for (int i = 0; i < 64; i++)
      mm.write_bit(id[i]);
  endtask : match

  // The device answers with its bit and complement unless it dropped out.
  task automatic search(input logic [7:0] cmd, input int n, input int stop,
                        input logic part);
    send_byte(cmd);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(part ? ID[i] : 1'b1);
      mm.read_bit();
      exp_q.push_back(part ? ~ID[i] : 1'b1);
      mm.read_bit();
      mm.write_bit(i == stop ? ~ID[i] : ID[i]);
      if (i == stop)
        part = 1'b0;
    end
  endtask : search

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    m_fast = 1'b0;
    quiet = 1'b0;
    {alarm_flag, high_trip_flag, low_trip_flag} = 3'b000;
    {reg_wr_en, func_tx_en, func_tx_bit} = 3'b000;
    reg_addr = 16'h0000;
    reg_wr_data = 8'h00;
    void'($urandom(29));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    reg_rd(CA, `SWR_CTRL_RESET);
    rv = $urandom;
    reg_wr(CA, rv[7:0]);
    reg_rd(CA, rv[7:0]);
    reg_wr(CA + 16'h0001, 8'hff);
    reg_rd(CA + 16'h0001, 8'h00);
    // A random address and its inverse toggle every address bit.
    ra = rv[31:16];
    if (ra == CA || ~ra == CA)
      ra = ra ^ 16'h0001;
    reg_wr(ra, 8'hff);
    reg_rd(~ra, 8'h00);
    reg_wr(~ra, 8'hff);
    reg_rd(ra, 8'h00);
    reg_rd(CA, rv[7:0]);
    chk(dq_out, 8'h00);
    wreset(210);
    send_byte(`SWR_CMD_SKIP);
    chk(selected, 8'h01);
    for (int i = 0; i < 4; i++) begin
      fb_q.push_back(rv[8 + i]);
      mm.write_bit(rv[8 + i]);
    end
    quiet = 1'b1;
    func_tx_en <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      func_tx_bit <= b[0];
      exp_q.push_back(b[0]);
      mm.read_bit();
    end
    func_tx_en <= 1'b0;
    quiet = 1'b0;
    wreset(210);
    match(`SWR_CMD_MATCH, ID);
    chk(selected, 8'h01);
    wreset(210);
    match(`SWR_CMD_MATCH, ID ^ 64'h0000_0000_0000_0020);
    chk(selected, 8'h00);
    exp_q.push_back(1'b1);
    mm.read_bit();
    wreset(210);
    send_byte(8'ha5);
    chk(selected, 8'h00);
    exp_q.push_back(1'b1);
    mm.read_bit();
    wreset(210);
    search(`SWR_CMD_SEARCH, 64, 99, 1'b1);
    wreset(210);
    search(`SWR_CMD_SEARCH, 12, 9, 1'b1);
    for (int c = 0; c < 3; c++) begin
      reg_wr(CA, 8'h01 << c);
      {low_trip_flag, high_trip_flag, alarm_flag} <=
          (3'b001 << c) | rv[26:24];
      wreset(210);
      search(`SWR_CMD_COND, 2, 99, 1'b1);
    end
    reg_wr(CA, 8'h01);
    {low_trip_flag, high_trip_flag, alarm_flag} <= 3'b110;
    wreset(210);
    search(`SWR_CMD_COND, 2, 99, 1'b0);
    reg_wr(CA, 8'h06);
    {low_trip_flag, high_trip_flag, alarm_flag} <= 3'b111;
    wreset(210);
    search(`SWR_CMD_COND, 64, 99, 1'b1);
    chk(selected, 8'h01);
    wreset(210);
    send_byte(`SWR_CMD_FSKIP);
    chk(fast_speed_flag, 8'h01);
    chk(selected, 8'h01);
    m_fast = 1'b1;
    wreset(50);
    chk(fast_speed_flag, 8'h01);
    match(`SWR_CMD_FMATCH, ~ID);
    chk(selected, 8'h00);
    chk(fast_speed_flag, 8'h01);
    m_fast = 1'b0;
    wreset(210);
    chk(fast_speed_flag, 8'h00);
    match(`SWR_CMD_FMATCH, ID);
    chk(selected, 8'h01);
    chk(fast_speed_flag, 8'h01);
    fb_q.push_back(rv[16]);
    mm.write_bit(rv[16]);
    m_fast = 1'b0;
    wreset(210);
    chk(fast_speed_flag, 8'h00);
    repeat (5) @(posedge clk);
    chk(8'(exp_q.size() + fb_q.size()), 8'h00);
    end_of_test();
  end
endmodule : test_swr_top
`default_nettype wire
